// >>> verilog/acq_seq_defines.svh
// Register offsets, field positions, reset values and timing counts of the scan sequencer
`ifndef ACQ_SEQ_DEFINES_SVH
`define ACQ_SEQ_DEFINES_SVH
`define ACQ_CLK_PS 8000
`define ACQ_SLOT_NS 1000
`define ACQ_SLOT_CYC ((`ACQ_SLOT_NS * 1000 + `ACQ_CLK_PS - 1) / `ACQ_CLK_PS)
`define ACQ_STEP_PS 20830
`define ACQ_LIST_DEPTH 512
`define ACQ_NUM_CNT 4
`define ACQ_REG_CTRL 8'h00
`define ACQ_REG_OVERSAMP 8'h04
`define ACQ_REG_DELAY_LO 8'h08
`define ACQ_REG_DELAY_HI 8'h0c
`define ACQ_REG_LIST_LEN 8'h10
`define ACQ_REG_LIST_ADDR 8'h14
`define ACQ_REG_LIST_DATA 8'h18
`define ACQ_REG_STATUS 8'h1c
`define ACQ_REG_DIG_LIVE 8'h20
`define ACQ_REG_CNT_LIVE 8'h24
`define ACQ_CTRL_RUN 0
`define ACQ_CTRL_PER_SAMPLE 1
`define ACQ_CTRL_AUTOZERO 2
`define ACQ_CTRL_DIG_EN 3
`define ACQ_CTRL_DIG_W_LSB 4
`define ACQ_CTRL_CNT_EN_LSB 8
`define ACQ_CTRL_CNT_32_LSB 12
`define ACQ_CTRL_MASK 32'h0000_ff3f
`define ACQ_CTRL_RST 32'h0000_0000
`define ACQ_OS_RST 8'h00
`define ACQ_DELAY_RST 42'h000_0000_0000
`define ACQ_LEN_RST 10'h000
`define ACQ_ENT_CHAN_LSB 0
`define ACQ_ENT_RANGE_LSB 6
`define ACQ_ENT_DIFF 9
`define ACQ_ENT_TEMP 10
`define ACQ_ENT_W 11
`endif

// >>> verilog/acq_seq_pkg.sv
// Types shared by the scan sequencer
package acq_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONV = 2'b01, ST_DELAY = 2'b10} seq_state_t;
  typedef enum logic [1:0] {PH_LIST = 2'b00, PH_COLD = 2'b01, PH_ZERO = 2'b10} seq_phase_t;
  typedef enum logic [1:0] {DW_8 = 2'b00, DW_16 = 2'b01, DW_24 = 2'b10} dig_width_t;
endpackage

// >>> verilog/acquisition_scan_sequencer.sv
// Scan sequencer: scan list, conversion slots, averaging, digital/counter merge, sample stream
`include "acq_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Holds a 512-entry scan list that software loads before acquisition.
// - Converts analog entries in order, one microsecond slot each without oversampling.
// - Restarts the scan at once or after a delay counted in 20.83 ns steps.
// - Each entry carries its own range of eight and single-ended or differential.
// - Software may read digital inputs and counters at any time.
// - Once-per-scan mode captures enabled digital inputs and counters in the first slot.
// - Digital and counter captures take no slot and never lengthen the scan.
// - The free start-of-scan capture happens only with at least one analog entry.
// - Per-sample mode captures enabled digital inputs with the first conversion of every entry.
// - In per-sample mode counters are still captured once per scan.
// - No digital samples are taken during the gap between scans.
// - Oversampling up to 256 applies to all analog entries, never digital or counters.
// - N oversamples take N one-microsecond conversions and return their 16-bit average.
// - One cold-junction reading is added per 4-channel block holding a temperature channel.
// - Cold-junction readings use the same oversampling count.
// - Autozero adds an entry converting the shorted input, lengthening the scan.
// - Each counter returns either its low 16 bits or its full 32 bits.
// - A 32-bit counter result goes out as a low-word and a high-word sample.
// - The digital entry returns 24 bits or narrower, 8 or 16 bits.
// - Every sample is 16 bits and streams to the host continuously.
module acquisition_scan_sequencer
  import acq_seq_pkg::*;
#(
  parameter int LIST_DEPTH = `ACQ_LIST_DEPTH,
  parameter int NUM_CNT = `ACQ_NUM_CNT
) (
  input wire logic sys_clk_i,                  // 125 MHz clock
  input wire logic sys_rst_i,                  // Synchronous reset, active high
  input wire logic wb_cyc_i,                   // Bus cycle
  input wire logic wb_stb_i,                   // Bus strobe
  input wire logic wb_we_i,                    // Write enable
  input wire logic [7:0] wb_adr_i,             // Byte address
  input wire logic [3:0] wb_sel_i,             // Byte lanes
  input wire logic [31:0] wb_dat_i,            // Write data
  output logic [31:0] wb_dat_o,                // Read data
  output logic wb_ack_o,                       // Acknowledge
  output logic adc_start_o,                    // Conversion start pulse
  output logic [5:0] adc_chan_o,               // Channel, or block for cold junction
  output logic [2:0] adc_range_o,              // Input range
  output logic adc_diff_o,                     // Differential input
  output logic adc_cold_o,                     // Cold-junction reading
  output logic adc_zero_o,                     // Shorted-input reading
  input wire logic [15:0] adc_data_i,          // Conversion result
  input wire logic [23:0] dig_in_i,            // Digital inputs
  input wire logic [NUM_CNT*32-1:0] cnt_i,     // Counter values
  output logic [15:0] smp_data_o,              // Sample word
  output logic smp_valid_o,                    // Sample valid
  input wire logic smp_ready_i                 // Host takes sample
);

  localparam int IDX_W = $clog2(LIST_DEPTH);
  localparam int SLOT_CYC = `ACQ_SLOT_CYC;
  localparam int SW = $clog2(SLOT_CYC);
  localparam int NITEM = 2 * NUM_CNT + 3;
  localparam int ANA = NITEM - 1;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] ctrl_r;
  logic [7:0] os_r;
  logic [41:0] dly_r;
  logic [IDX_W:0] len_r;
  logic [IDX_W-1:0] laddr_r;
  logic [`ACQ_ENT_W-1:0] list_mem [LIST_DEPTH];
  logic ack_r;
  logic [31:0] rdat_r;
  logic [15:0] scan_cnt_r;
  seq_state_t state_r;
  logic req;
  logic wr;

  function automatic logic [31:0] merge32(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `ACQ_CTRL_RST;
      os_r <= `ACQ_OS_RST;
      dly_r <= `ACQ_DELAY_RST;
      len_r <= `ACQ_LEN_RST;
      laddr_r <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        `ACQ_REG_CTRL: ctrl_r <= merge32(ctrl_r, wb_dat_i, wb_sel_i) & `ACQ_CTRL_MASK;
        `ACQ_REG_OVERSAMP: if (wb_sel_i[0]) os_r <= wb_dat_i[7:0];
        `ACQ_REG_DELAY_LO: dly_r[31:0] <= merge32(dly_r[31:0], wb_dat_i, wb_sel_i);
        `ACQ_REG_DELAY_HI: dly_r[41:32] <= 10'(merge32({22'h0, dly_r[41:32]}, wb_dat_i, wb_sel_i));
        `ACQ_REG_LIST_LEN: begin
          // Longer lengths are clamped to the list size
          if (wb_dat_i[15:0] > 16'(LIST_DEPTH)) begin
            len_r <= (IDX_W+1)'(LIST_DEPTH);
          end else begin
            len_r <= wb_dat_i[IDX_W:0];
          end
        end
        `ACQ_REG_LIST_ADDR: laddr_r <= wb_dat_i[IDX_W-1:0];
        `ACQ_REG_LIST_DATA: begin
          // Loading is only honoured while idle so a running scan never sees a torn list
          if (state_r == ST_IDLE) begin
            laddr_r <= laddr_r + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr && wb_adr_i == `ACQ_REG_LIST_DATA && state_r == ST_IDLE) begin
      list_mem[laddr_r] <= wb_dat_i[`ACQ_ENT_W-1:0];
    end
  end

  // Live reads are untimed with respect to the scan
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (req) begin
      rdat_r <= 32'h0000_0000;
      case (wb_adr_i)
        `ACQ_REG_CTRL: rdat_r <= ctrl_r;
        `ACQ_REG_OVERSAMP: rdat_r <= {24'h00_0000, os_r};
        `ACQ_REG_DELAY_LO: rdat_r <= dly_r[31:0];
        `ACQ_REG_DELAY_HI: rdat_r <= {22'h00_0000, dly_r[41:32]};
        `ACQ_REG_LIST_LEN: rdat_r <= 32'(len_r);
        `ACQ_REG_LIST_ADDR: rdat_r <= 32'(laddr_r);
        `ACQ_REG_LIST_DATA: rdat_r <= 32'(list_mem[laddr_r]);
        `ACQ_REG_STATUS: rdat_r <= {scan_cnt_r, 14'h0000, state_r == ST_DELAY,
                                    state_r != ST_IDLE};
        `ACQ_REG_DIG_LIVE: rdat_r <= {8'h00, dig_in_i};
        default: begin
          for (int i = 0; i < NUM_CNT; i++) begin
            if (wb_adr_i == 8'(`ACQ_REG_CNT_LIVE + 4 * i)) begin
              rdat_r <= cnt_i[i*32 +: 32];
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Scan walk
  // ****************************************************************
  logic run;
  logic per_sample;
  logic autozero;
  logic dig_en;
  dig_width_t dig_w;
  logic [NUM_CNT-1:0] cnt_en;
  logic [NUM_CNT-1:0] cnt_32;
  seq_phase_t ph_r;
  logic [IDX_W-1:0] idx_r;
  logic [15:0] cold_mask_r;
  logic ent_temp_r;
  logic first_r;
  logic [SW-1:0] slot_r;
  logic [7:0] os_cnt_r;
  logic [23:0] sum_r;
  logic [14:0] acc_r;
  logic [41:0] dly_cnt_r;
  logic [NITEM-1:0] pend_r;
  logic [NITEM-1:0] hold_r;
  logic [NITEM-1:0] cap_mask;
  logic div_busy_r;
  logic ent_start;
  logic start_stall;
  logic last_cyc;
  logic last_os;
  logic end_stall;
  logic ent_done;
  logic tick;
  logic [15:0] mask_nxt;
  logic [3:0] blk_nxt;
  seq_phase_t ph_nxt;
  logic scan_end;
  logic [`ACQ_ENT_W-1:0] ent_nxt;

  assign run = ctrl_r[`ACQ_CTRL_RUN];
  assign per_sample = ctrl_r[`ACQ_CTRL_PER_SAMPLE];
  assign autozero = ctrl_r[`ACQ_CTRL_AUTOZERO];
  assign dig_en = ctrl_r[`ACQ_CTRL_DIG_EN];
  assign dig_w = dig_width_t'(ctrl_r[`ACQ_CTRL_DIG_W_LSB +: 2]);
  assign cnt_en = ctrl_r[`ACQ_CTRL_CNT_EN_LSB +: NUM_CNT];
  assign cnt_32 = ctrl_r[`ACQ_CTRL_CNT_32_LSB +: NUM_CNT];

  // Captures are raised against the first conversion of an entry, not a slot of their own
  always_comb begin
    cap_mask = '0;
    if (dig_en && (first_r || per_sample)) begin
      cap_mask[0] = 1'b1;
      cap_mask[1] = (dig_w == DW_24);
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      cap_mask[2+2*i] = first_r && cnt_en[i];
      cap_mask[3+2*i] = first_r && cnt_en[i] && cnt_32[i];
    end
  end

  // Host back-pressure is the only thing that can stretch a slot
  assign start_stall = (hold_r != '0) || ((pend_r & cap_mask) != '0);
  assign ent_start = (state_r == ST_CONV) && (slot_r == '0) && (os_cnt_r == 8'h00) && !start_stall;
  assign last_cyc = (state_r == ST_CONV) && (slot_r == SW'(SLOT_CYC - 1));
  assign last_os = (os_cnt_r == os_r);
  assign end_stall = last_os && (div_busy_r || pend_r[ANA]);
  assign ent_done = last_cyc && last_os && !end_stall;
  assign tick = (32'(acc_r) + `ACQ_CLK_PS) >= `ACQ_STEP_PS;

  // Next entry: list, then one cold-junction read per marked block, then autozero
  always_comb begin
    mask_nxt = cold_mask_r;
    if (ph_r == PH_LIST && ent_temp_r) begin
      mask_nxt[adc_chan_o[5:2]] = 1'b1;
    end
    blk_nxt = 4'h0;
    for (int b = 15; b >= 0; b--) begin
      if (mask_nxt[b]) blk_nxt = 4'(b);
    end
    scan_end = 1'b0;
    ph_nxt = ph_r;
    ent_nxt = list_mem[idx_r + 1'b1];
    if (ph_r == PH_LIST && (32'(idx_r) + 1) < 32'(len_r)) begin
      ph_nxt = PH_LIST;
    end else if (ph_r != PH_ZERO && mask_nxt != 16'h0000) begin
      ph_nxt = PH_COLD;
    end else if (ph_r != PH_ZERO && autozero) begin
      ph_nxt = PH_ZERO;
    end else begin
      scan_end = 1'b1;
      ent_nxt = list_mem[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      ph_r <= PH_LIST;
      idx_r <= '0;
      cold_mask_r <= 16'h0000;
      first_r <= 1'b0;
      slot_r <= '0;
      os_cnt_r <= 8'h00;
      scan_cnt_r <= 16'h0000;
      acc_r <= 15'h0000;
      dly_cnt_r <= 42'h000_0000_0000;
      adc_chan_o <= 6'h00;
      adc_range_o <= 3'h0;
      adc_diff_o <= 1'b0;
      adc_cold_o <= 1'b0;
      adc_zero_o <= 1'b0;
      ent_temp_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // An empty list never starts, so no capture can run without an analog entry
          if (run && len_r != '0) begin
            state_r <= ST_CONV;
            ph_r <= PH_LIST;
            idx_r <= '0;
            cold_mask_r <= 16'h0000;
            first_r <= 1'b1;
            slot_r <= '0;
            os_cnt_r <= 8'h00;
            {ent_temp_r, adc_diff_o, adc_range_o, adc_chan_o} <= list_mem[0];
            adc_cold_o <= 1'b0;
            adc_zero_o <= 1'b0;
          end
        end
        ST_CONV: begin
          if (slot_r == '0 && os_cnt_r == 8'h00 && start_stall) begin
            slot_r <= '0;
          end else if (!last_cyc) begin
            slot_r <= slot_r + 1'b1;
          end else if (!last_os) begin
            slot_r <= '0;
            os_cnt_r <= os_cnt_r + 8'h01;
          end else if (!end_stall) begin
            slot_r <= '0;
            os_cnt_r <= 8'h00;
            first_r <= 1'b0;
            cold_mask_r <= mask_nxt;
            adc_cold_o <= 1'b0;
            adc_zero_o <= 1'b0;
            if (scan_end) begin
              scan_cnt_r <= scan_cnt_r + 16'h0001;
              cold_mask_r <= 16'h0000;
              ph_r <= PH_LIST;
              idx_r <= '0;
              {ent_temp_r, adc_diff_o, adc_range_o, adc_chan_o} <= ent_nxt;
              if (!run) begin
                state_r <= ST_IDLE;
              end else if (dly_r == 42'h000_0000_0000) begin
                first_r <= 1'b1;
              end else begin
                state_r <= ST_DELAY;
                acc_r <= 15'h0000;
                dly_cnt_r <= 42'h000_0000_0000;
              end
            end else if (ph_nxt == PH_LIST) begin
              idx_r <= idx_r + 1'b1;
              {ent_temp_r, adc_diff_o, adc_range_o, adc_chan_o} <= ent_nxt;
            end else if (ph_nxt == PH_COLD) begin
              ph_r <= PH_COLD;
              cold_mask_r[blk_nxt] <= 1'b0;
              ent_temp_r <= 1'b0;
              {adc_diff_o, adc_range_o} <= 4'h0;
              adc_chan_o <= {2'b00, blk_nxt};
              adc_cold_o <= 1'b1;
            end else begin
              ph_r <= PH_ZERO;
              ent_temp_r <= 1'b0;
              {adc_diff_o, adc_range_o, adc_chan_o} <= 10'h000;
              adc_zero_o <= 1'b1;
            end
          end
        end
        ST_DELAY: begin
          // Fractional step count keeps 20.83 ns steps exact on average
          acc_r <= tick ? 15'(32'(acc_r) + `ACQ_CLK_PS - `ACQ_STEP_PS)
                        : 15'(32'(acc_r) + `ACQ_CLK_PS);
          if (!run) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            dly_cnt_r <= dly_cnt_r + 42'h000_0000_0001;
            if (dly_cnt_r + 42'h000_0000_0001 >= dly_r) begin
              state_r <= ST_CONV;
              first_r <= 1'b1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign adc_start_o = (state_r == ST_CONV) && (slot_r == '0) && !(os_cnt_r == 8'h00 && start_stall);

  // ****************************************************************
  // Averaging
  // ****************************************************************
  logic [4:0] div_cnt_r;
  logic [23:0] div_num_r;
  logic [9:0] div_rem_r;
  logic [15:0] avg_r;
  logic div_done;
  logic [9:0] div_sh;
  logic [9:0] div_den;

  assign div_den = {1'b0, 9'(os_r) + 9'h001};
  assign div_sh = {div_rem_r[8:0], div_num_r[23]};
  assign div_done = div_busy_r && (div_cnt_r == 5'h17);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sum_r <= 24'h00_0000;
      div_busy_r <= 1'b0;
      div_cnt_r <= 5'h00;
      div_num_r <= 24'h00_0000;
      div_rem_r <= 10'h000;
      avg_r <= 16'h0000;
    end else begin
      if (last_cyc && !end_stall) begin
        sum_r <= last_os ? 24'h00_0000 : sum_r + 24'(adc_data_i);
      end
      if (ent_done) begin
        div_busy_r <= 1'b1;
        div_cnt_r <= 5'h00;
        div_num_r <= sum_r + 24'(adc_data_i);
        div_rem_r <= 10'h000;
      end else if (div_busy_r) begin
        div_cnt_r <= div_cnt_r + 5'h01;
        div_num_r <= {div_num_r[22:0], div_sh >= div_den};
        div_rem_r <= (div_sh >= div_den) ? div_sh - div_den : div_sh;
        if (div_done) begin
          div_busy_r <= 1'b0;
          avg_r <= {div_num_r[14:0], div_sh >= div_den};
        end
      end
    end
  end

  // ****************************************************************
  // Capture and sample stream
  // ****************************************************************
  logic [23:0] cap_dig_r;
  logic [31:0] cap_cnt_r [NUM_CNT];
  logic [NITEM-1:0] take;
  logic [15:0] word;
  logic load_out;
  logic release_hold;
  logic [15:0] smp_data_r;
  logic smp_valid_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cap_dig_r <= 24'h00_0000;
    end else if (ent_start && cap_mask[0]) begin
      cap_dig_r <= dig_in_i;
    end
  end

  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        cap_cnt_r[g] <= 32'h0000_0000;
      end else if (ent_start && cap_mask[2+2*g]) begin
        cap_cnt_r[g] <= cnt_i[g*32 +: 32];
      end
    end
  end

  // Captures wait until the previous entry's average has left, which fixes the order
  assign release_hold = (hold_r != '0) && !div_busy_r && !pend_r[ANA];
  assign load_out = (pend_r != '0) && (!smp_valid_r || smp_ready_i);

  always_comb begin
    take = '0;
    word = avg_r;
    for (int k = NITEM - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        take = '0;
        take[k] = 1'b1;
      end
    end
    for (int k = 0; k < NITEM - 1; k++) begin
      if (take[k]) begin
        if (k == 0) begin
          word = (dig_w == DW_8) ? {8'h00, cap_dig_r[7:0]} : cap_dig_r[15:0];
        end else if (k == 1) begin
          word = {8'h00, cap_dig_r[23:16]};
        end else begin
          word = cap_cnt_r[(k-2)/2][((k-2)%2)*16 +: 16];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hold_r <= '0;
      pend_r <= '0;
      smp_data_r <= 16'h0000;
      smp_valid_r <= 1'b0;
    end else begin
      if (ent_start) begin
        hold_r <= cap_mask;
      end else if (release_hold) begin
        hold_r <= '0;
      end
      pend_r <= (pend_r & ~(load_out ? take : '0)) | (release_hold ? hold_r : '0)
                | (div_done ? NITEM'(1) << ANA : '0);
      if (load_out) begin
        smp_data_r <= word;
        smp_valid_r <= 1'b1;
      end else if (smp_ready_i) begin
        smp_valid_r <= 1'b0;
      end
    end
  end

  assign smp_data_o = smp_data_r;
  assign smp_valid_o = smp_valid_r;

endmodule

`default_nettype wire

// >>> dv/seq_props.sv
// Concurrent checks on the scan sequencer ports
`timescale 1ns/1ps
`default_nettype none
module seq_props (
  input wire logic sys_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Acknowledge
  input wire logic adc_start_o, // Conversion start
  input wire logic [2:0] adc_range_o, // Range
  input wire logic adc_diff_o, // Differential
  input wire logic adc_cold_o, // Cold junction
  input wire logic adc_zero_o, // Autozero
  input wire logic [15:0] smp_data_o, // Sample
  input wire logic smp_valid_o, // Valid
  input wire logic smp_ready_i // Ready
);
  logic [7:0] gap_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Saturates so a long idle never wraps into a false short gap
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) gap_r <= 8'hff;
    else if (adc_start_o) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  slot_gap_a: assert property (adc_start_o |-> gap_r >= 8'h7c)
    else $error("conversion slot shorter than 125 cycles");
  start_pulse_a: assert property (adc_start_o |=> !adc_start_o) else $error("start not a pulse");
  sample_hold_a: assert property (smp_valid_o && !smp_ready_i |=>
    smp_valid_o && $stable(smp_data_o)) else $error("sample dropped or changed while stalled");
  cold_range_a: assert property (adc_cold_o |-> adc_range_o == 3'h0 && !adc_diff_o)
    else $error("cold junction read with wrong input setup");
  entry_kind_a: assert property (!(adc_cold_o && adc_zero_o))
    else $error("cold junction and autozero at once");
  reset_quiet_a: assert property ($past(sys_rst_i) |-> !smp_valid_o && !wb_ack_o && !adc_start_o)
    else $error("activity right after reset");
  cover property (adc_cold_o && adc_start_o);
  cover property (smp_valid_o && !smp_ready_i);
  cover property (wb_ack_o);
endmodule
bind acquisition_scan_sequencer seq_props i_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .adc_start_o(adc_start_o),
  .adc_range_o(adc_range_o), .adc_diff_o(adc_diff_o), .adc_cold_o(adc_cold_o),
  .adc_zero_o(adc_zero_o), .smp_data_o(smp_data_o), .smp_valid_o(smp_valid_o),
  .smp_ready_i(smp_ready_i));
`default_nettype wire

// >>> dv/host_adc_model.sv
// Host sample sink and converter stand-in for the scan sequencer bench
`timescale 1ns/1ps
`default_nettype none
module host_adc_model (
  input wire logic sys_clk_i, // Clock
  input wire logic stall_i, // Throttle the host
  input wire logic adc_start_o, // Conversion start
  input wire logic [5:0] adc_chan_o, // Channel or block
  input wire logic adc_cold_o, // Cold junction
  input wire logic adc_zero_o, // Autozero
  output logic [15:0] adc_data_i, // Conversion result
  input wire logic [15:0] smp_data_o, // Sample
  input wire logic smp_valid_o, // Valid
  output logic smp_ready_i // Host takes sample
);
  logic odd_r = 1'b0;
  logic [15:0] got[$];
  initial adc_data_i = 16'h0000;
  initial smp_ready_i = 1'b1;
  // Readings alternate base and base+4, so a pair averages to base+2
  always @(posedge sys_clk_i) begin
    if (adc_start_o) begin
      adc_data_i <= {adc_cold_o, adc_zero_o, 8'h00, adc_chan_o} + (odd_r ? 16'h0004 : 16'h0000);
      odd_r <= !odd_r;
    end
    if (smp_valid_o && smp_ready_i) got.push_back(smp_data_o);
    smp_ready_i <= stall_i ? !smp_ready_i : 1'b1;
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acq_seq_defines.svh"
module tb;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dato, v;
  logic ack, start, diff, cold, zero, svalid, sready;
  logic stall = 1'b1;
  logic [5:0] chan;
  logic [2:0] rng;
  logic [15:0] adata, sdata;
  logic [15:0] exp_q[9] = '{16'hcdef, 16'h5678, 16'h1234, 16'h0003, 16'h0007, 16'h8003,
    16'hcdef, 16'h5678, 16'h1234};
  // Per-sample mode with autozero, N=1: digital word per entry, counter once per scan
  logic [15:0] exp2[12] = '{16'h00ef, 16'h5678, 16'h0001, 16'h00ef, 16'h0009, 16'h00ef,
    16'h8001, 16'h00ef, 16'h4004, 16'h00ef, 16'h5678, 16'h0001};
  logic [7:0] regs[5] = '{`ACQ_REG_CTRL, `ACQ_REG_OVERSAMP, `ACQ_REG_LIST_LEN, `ACQ_REG_STATUS, 8'h40};
  int fails = 0;
  int n_checks = 0;
  acquisition_scan_sequencer i_acquisition_scan_sequencer (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .adc_start_o(start),
    .adc_chan_o(chan), .adc_range_o(rng), .adc_diff_o(diff), .adc_cold_o(cold), .adc_zero_o(zero),
    .adc_data_i(adata), .dig_in_i(24'habcdef), .cnt_i({96'h0, 32'h1234_5678}), .smp_data_o(sdata),
    .smp_valid_o(svalid), .smp_ready_i(sready));
  host_adc_model i_model (.sys_clk_i(sys_clk_i), .stall_i(stall), .adc_start_o(start),
    .adc_chan_o(chan), .adc_cold_o(cold), .adc_zero_o(zero), .adc_data_i(adata),
    .smp_data_o(sdata), .smp_valid_o(svalid), .smp_ready_i(sready));
  // ****************************************
  // Bus access and checking
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Entered just after a rising edge; returns one cycle after the ack edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge sys_clk_i);
    while (ack !== 1'b1) @(posedge sys_clk_i);
    v = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    forever #4 sys_clk_i = !sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 32'h0);
      chk("reset or unmapped read", 32'h0, v);
    end
    acc(1'b1, `ACQ_REG_CTRL, 32'hffff_fffb);
    acc(1'b0, `ACQ_REG_CTRL, 32'h0);
    chk("control readback", 32'h0000_ff3b, v);
    repeat (300) @(posedge sys_clk_i);
    chk("samples with empty list", 32'h0, i_model.got.size());
    acc(1'b1, `ACQ_REG_CTRL, 32'h0);
    $display("register test done");
    acc(1'b1, `ACQ_REG_LIST_ADDR, 32'h1ff);
    acc(1'b1, `ACQ_REG_LIST_DATA, 32'h7ff);
    acc(1'b1, `ACQ_REG_LIST_ADDR, 32'h1ff);
    acc(1'b0, `ACQ_REG_LIST_DATA, 32'h0);
    chk("last list entry", 32'h7ff, v);
    acc(1'b1, `ACQ_REG_LIST_ADDR, 32'h0);
    acc(1'b1, `ACQ_REG_LIST_DATA, 32'h381);
    acc(1'b1, `ACQ_REG_LIST_DATA, 32'h485);
    acc(1'b1, `ACQ_REG_OVERSAMP, 32'h1);
    acc(1'b1, `ACQ_REG_LIST_LEN, 32'h2);
    acc(1'b1, `ACQ_REG_CTRL, 32'h0000_1119);
    while (i_model.got.size() < 16) @(posedge sys_clk_i);
    foreach (exp_q[i]) chk("once per scan word", exp_q[i], i_model.got[i]);
    acc(1'b1, `ACQ_REG_CTRL, 32'h0);
    do acc(1'b0, `ACQ_REG_STATUS, 32'h0); while (v[0] !== 1'b0);
    // The last entry's average still leaves after the scan has gone idle
    repeat (100) @(posedge sys_clk_i);
    i_model.got.delete();
    $display("once per scan test done");
    stall <= 1'b0;
    acc(1'b1, `ACQ_REG_OVERSAMP, 32'h0);
    acc(1'b1, `ACQ_REG_CTRL, 32'h0000_010f);
    while (i_model.got.size() < 12) @(posedge sys_clk_i);
    chk("first digital word", 32'h00ef, i_model.got[0]);
    chk("second entry digital word", 32'h00ef, i_model.got[3]);
    foreach (exp2[i]) chk("per sample word", exp2[i], i_model.got[i]);
    $display("per sample test done");
    end_of_test();
  end
endmodule
`default_nettype wire
